// [logic/two_d_sliding_window_regs.v]
// two-dimensional sliding window held in individual registers
// What this block does
// - rows, columns and element width are build-time parameters.
// - each element lives in its own register, all reachable at once.
// - shift up moves each row from the row below; bottom row left undefined.
// - shift down moves each row from the row above; top row left undefined.
// - shift left moves each column from its right neighbour; rightmost vacated.
// - shift right moves each column from its left neighbour; leftmost vacated.
// - vacated elements hold arbitrary values until written again.
// - shifts only move data; new data enters only by insert operations.
// - element write stores value at row and column, nothing else changes.
// - indexed row or column write replaces exactly that line, no shifting.
// - bottom-edge write replaces the last row from a vector, no index.
// - top, left and right edge writes replace their own boundary line.
// - read returns any element's current value without changing contents.
`default_nettype none
`include "window_defines.vh"

module two_d_sliding_window_regs #(
    parameter ROWS   = `WIN_ROWS_DEF,
    parameter COLS   = `WIN_COLS_DEF,
    parameter DATA_W = `WIN_DATA_W_DEF,
    parameter ROW_IW = 2,
    parameter COL_IW = 2
) (
    input  wire                      mclk_in,
    input  wire                      arst_n_in,
    input  wire [`WIN_OP_W-1:0]      op_in,
    input  wire [ROW_IW-1:0]         wr_row_in,
    input  wire [COL_IW-1:0]         wr_col_in,
    input  wire [DATA_W-1:0]         wr_value_in,
    input  wire [COLS*DATA_W-1:0]    row_vec_in,
    input  wire [ROWS*DATA_W-1:0]    col_vec_in,
    input  wire [ROW_IW-1:0]         rd_row_in,
    input  wire [COL_IW-1:0]         rd_col_in,
    output reg  [DATA_W-1:0]         rd_value_out,
    output reg  [ROWS*COLS*DATA_W-1:0] window_out
);

    localparam N = ROWS * COLS;

    // one flat register per element; element (r,c) at index r*COLS+c
    reg  [DATA_W-1:0] elem_q [0:N-1];
    reg  [DATA_W-1:0] elem_d [0:N-1];
    integer r;
    integer c;
    // the clocked loop has its own index so no variable is driven from two processes
    integer i;

    // vacated lines simply keep their old contents: cheapest legal choice
    always @* begin
        for (r = 0; r < ROWS; r = r + 1) begin
            for (c = 0; c < COLS; c = c + 1) begin
                elem_d[r*COLS+c] = elem_q[r*COLS+c];
                case (op_in)
                    `WIN_OP_SHIFT_UP: begin
                        if (r < ROWS-1) elem_d[r*COLS+c] = elem_q[(r+1)*COLS+c];
                    end
                    `WIN_OP_SHIFT_DOWN: begin
                        if (r > 0) elem_d[r*COLS+c] = elem_q[(r-1)*COLS+c];
                    end
                    `WIN_OP_SHIFT_LEFT: begin
                        if (c < COLS-1) elem_d[r*COLS+c] = elem_q[r*COLS+c+1];
                    end
                    `WIN_OP_SHIFT_RGHT: begin
                        if (c > 0) elem_d[r*COLS+c] = elem_q[r*COLS+c-1];
                    end
                    `WIN_OP_PUT_ELEM: begin
                        if (wr_row_in == r && wr_col_in == c)
                            elem_d[r*COLS+c] = wr_value_in;
                    end
                    `WIN_OP_PUT_ROW: begin
                        if (wr_row_in == r)
                            elem_d[r*COLS+c] = row_vec_in[c*DATA_W +: DATA_W];
                    end
                    `WIN_OP_PUT_COL: begin
                        if (wr_col_in == c)
                            elem_d[r*COLS+c] = col_vec_in[r*DATA_W +: DATA_W];
                    end
                    `WIN_OP_PUT_BOTTOM: begin
                        if (r == ROWS-1)
                            elem_d[r*COLS+c] = row_vec_in[c*DATA_W +: DATA_W];
                    end
                    `WIN_OP_PUT_TOP: begin
                        if (r == 0)
                            elem_d[r*COLS+c] = row_vec_in[c*DATA_W +: DATA_W];
                    end
                    `WIN_OP_PUT_LEFT: begin
                        if (c == 0)
                            elem_d[r*COLS+c] = col_vec_in[r*DATA_W +: DATA_W];
                    end
                    `WIN_OP_PUT_RIGHT: begin
                        if (c == COLS-1)
                            elem_d[r*COLS+c] = col_vec_in[r*DATA_W +: DATA_W];
                    end
                    default: begin
                        elem_d[r*COLS+c] = elem_q[r*COLS+c];
                    end
                endcase
            end
        end
    end

    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (i = 0; i < N; i = i + 1) begin
                elem_q[i] <= {DATA_W{`WIN_RESET_VAL}};
            end
            rd_value_out <= {DATA_W{`WIN_RESET_VAL}};
            window_out   <= {(N*DATA_W){`WIN_RESET_VAL}};
        end else begin
            for (i = 0; i < N; i = i + 1) begin
                elem_q[i] <= elem_d[i];
                window_out[i*DATA_W +: DATA_W] <= elem_d[i];
            end
            // read sees contents before this cycle's operation; out of range reads zero
            if (rd_row_in < ROWS && rd_col_in < COLS)
                rd_value_out <= elem_q[rd_row_in*COLS + rd_col_in];
            else
                rd_value_out <= {DATA_W{`WIN_RESET_VAL}};
        end
    end

endmodule
`default_nettype wire

// [logic/window_defines.vh]
// operation codes and default dimensions for the sliding window store
`ifndef WINDOW_DEFINES_VH
`define WINDOW_DEFINES_VH

`define WIN_OP_W          4
`define WIN_OP_NONE       4'h0
`define WIN_OP_SHIFT_UP   4'h1
`define WIN_OP_SHIFT_DOWN 4'h2
`define WIN_OP_SHIFT_LEFT 4'h3
`define WIN_OP_SHIFT_RGHT 4'h4
`define WIN_OP_PUT_ELEM   4'h5
`define WIN_OP_PUT_ROW    4'h6
`define WIN_OP_PUT_COL    4'h7
`define WIN_OP_PUT_BOTTOM 4'h8
`define WIN_OP_PUT_TOP    4'h9
`define WIN_OP_PUT_LEFT   4'hA
`define WIN_OP_PUT_RIGHT  4'hB

`define WIN_ROWS_DEF      3
`define WIN_COLS_DEF      3
`define WIN_DATA_W_DEF    8
`define WIN_RESET_VAL     1'b0

`endif

// [test/window_chk_sv_chk.sv]
// port assertions for the sliding window store
`default_nettype none
module window_chk #(parameter int ROWS=3, COLS=3, DATA_W=8, ROW_IW=2, COL_IW=2) (
    input wire logic mclk_in, arst_n_in, input wire logic [3:0] op_in,
    input wire logic [ROW_IW-1:0] rd_row_in, input wire logic [DATA_W-1:0] rd_value_out,
    input wire logic [COLS*DATA_W-1:0] row_vec_in,
    input wire logic [ROWS*COLS*DATA_W-1:0] window_out);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = COLS*DATA_W, L = W*(ROWS-1);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_idle; (op_in == 4'h0) [*2]; endsequence
    property p_up; op_in == 4'h1 |=> window_out[L-1:0] == $past(window_out[L+W-1:W]); endproperty
    a_up: assert property (p_up) else $error("bad shift up");
    property p_down; op_in == 4'h2 |=> window_out[L+W-1:W] == $past(window_out[L-1:0]); endproperty
    a_down: assert property (p_down) else $error("bad shift down");
    property p_bot; op_in == 4'h8 |=> window_out[L+W-1:L] == $past(row_vec_in); endproperty
    a_bot: assert property (p_bot) else $error("bad bottom row");
    property p_idle; s_idle |-> $stable(window_out); endproperty
    a_idle: assert property (p_idle) else $error("window moved while idle");
    property p_bad; op_in > 4'hB |=> $stable(window_out); endproperty
    a_bad: assert property (p_bad) else $error("unknown op changed window");
    property p_oor; rd_row_in >= ROWS |=> rd_value_out == '0; endproperty
    a_oor: assert property (p_oor) else $error("out of range read not zero");
endmodule
bind two_d_sliding_window_regs window_chk #(.ROWS(ROWS), .COLS(COLS), .DATA_W(DATA_W),
    .ROW_IW(ROW_IW), .COL_IW(COL_IW)) u_window_chk (.*);
`default_nettype wire

// [test/op_src.sv]
// far-side datapath model issuing one window operation per cycle
`default_nettype none
module op_src (input wire logic clk_in, output logic [3:0] op_out,
    output logic [1:0] row_out, col_out, output logic [7:0] val_out, output logic [23:0] vec_out);
    timeunit 1ns;
    timeprecision 1ps;
    initial {op_out, row_out, col_out, val_out, vec_out} = '0;
    // changes just after an edge, so each request stands for exactly one cycle
    task automatic put(input logic [3:0] o, input logic [1:0] r, c, input logic [7:0] v,
        input logic [23:0] x);
        @(posedge clk_in);
        #1 {op_out, row_out, col_out, val_out, vec_out} = {o, r, c, v, x};
    endtask
endmodule
`default_nettype wire

// [test/tb_two_d_sliding_window_regs.sv]
// self-checking bench for the sliding window store
`default_nettype none
module tb_two_d_sliding_window_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 0, arst_n_in = 0;
    logic [1:0] rr = 0, rc = 0, wr, wc;
    logic [3:0] op;
    logic [7:0] v, rd, m [3][3], t [3][3];
    logic [23:0] x, y;
    logic [71:0] w;
    int error_cnt = 0, n_compared = 0, cyc = 0, k;
    always #4 mclk_in = ~mclk_in;
    op_src u_op_src (.clk_in(mclk_in), .op_out(op), .row_out(wr), .col_out(wc), .val_out(v),
        .vec_out(x));
    two_d_sliding_window_regs u_two_d_sliding_window_regs (.mclk_in, .arst_n_in, .op_in(op),
        .wr_row_in(wr), .wr_col_in(wc), .wr_value_in(v), .row_vec_in(x), .col_vec_in(x),
        .rd_row_in(rr), .rd_col_in(rc), .rd_value_out(rd), .window_out(w));
    always @(posedge mclk_in) if (++cyc == 500) begin error_cnt++; stop_test(); end
    task automatic cmp(input logic [7:0] g, e);
        n_compared++;
        if (g !== e) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, g, e); end
    endtask
    task automatic chk(); for (int i = 0; i < 9; i++) cmp(w[i*8 +: 8], m[i/3][i%3]); endtask
    task automatic t_ins();
        for (int i = 0; i < 9; i++) m[i/3][i%3] = i%3 == 2 ? 8'h50 + 8'(i/3) : 8'(i);
        m[1][1] = 8'h64;
        for (int r = 0; r < 3; r++) u_op_src.put(4'h6, 2'(r), 0, 0, {8'(3*r+2), 8'(3*r+1), 8'(3*r)});
        u_op_src.put(4'h5, 1, 1, 8'h64, 0);
        u_op_src.put(4'h7, 0, 2, 0, 24'h525150);
        u_op_src.put(4'hC, 0, 0, 0, 24'hFFFFFF);
        u_op_src.put(4'h0, 0, 0, 0, 0);
        chk();
        rc = 1; repeat (2) @(posedge mclk_in); #1 cmp(rd, m[0][1]);
        rr = 3; repeat (2) @(posedge mclk_in); #1 cmp(rd, 8'h00);
        $display("insert and read test done");
    endtask
    task automatic t_shift();
        for (int d = 0; d < 4; d++) begin
            t = m;
            for (int i = 0; i < 9; i++) begin
                m[i/3][i%3] = 8'hA0 + 8'(d*9 + i);
                case (d)
                    0: if (i < 6) m[i/3][i%3] = t[i/3+1][i%3];
                    1: if (i > 2) m[i/3][i%3] = t[i/3-1][i%3];
                    2: if (i%3 < 2) m[i/3][i%3] = t[i/3][i%3+1];
                    default: if (i%3 > 0) m[i/3][i%3] = t[i/3][i%3-1];
                endcase
            end
            // vacated line is refilled at once, its old contents are never trusted
            k = d < 2 ? 2 - 2*d : 6 - 2*d;
            y = d < 2 ? {m[k][2], m[k][1], m[k][0]} : {m[2][k], m[1][k], m[0][k]};
            u_op_src.put(4'(d + 1), 0, 0, 0, 0);
            u_op_src.put(d == 0 ? 4'h8 : d == 1 ? 4'h9 : d == 2 ? 4'hB : 4'hA, 0, 0, 0, y);
            u_op_src.put(4'h0, 0, 0, 0, 0);
            chk();
        end
        $display("shift test done");
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk_in);
        #1 arst_n_in = 1;
        t_ins();
        t_shift();
        stop_test();
    end
endmodule
`default_nettype wire
